//--- inc/sps_pkg.sv
// constants and types for the closed-loop speed regulator with status led
package sps_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int UPDATE_MS = 16;
  localparam int UPDATE_CYC = CLK_HZ / 1000 * UPDATE_MS;
  localparam int STARTUP_MS = 1000;
  localparam int STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;
  localparam int BLINK_SLOW_MS = 250;
  localparam int BLINK_SLOW_CYC = CLK_HZ / 1000 * BLINK_SLOW_MS;
  localparam int BLINK_FAST_MS = 50;
  localparam int BLINK_FAST_CYC = CLK_HZ / 1000 * BLINK_FAST_MS;
  localparam logic [7:0] ADC_MID = 8'h80;
  localparam logic signed [7:0] SPD_MAX = 8'sh7f;
  localparam logic signed [7:0] SPD_MIN = -8'sh7f;
  localparam logic signed [15:0] INT_LIM = 16'sh3fff;
  localparam logic signed [7:0] PWR_MAX = 8'sh7f;
  localparam logic signed [7:0] PWR_MIN = -8'sh7f;
  localparam int GAIN_SHIFT = 4;
  typedef enum logic [2:0] {
    SPS_MODE_OPEN,
    SPS_MODE_SPD_SEP,
    SPS_MODE_SPD_MIX,
    SPS_MODE_SPD_POS,
    SPS_MODE_POS
  } sps_mode_t;
  typedef enum {
    SPS_ST_START,
    SPS_ST_RUN,
    SPS_ST_HOLD,
    SPS_ST_LATCH
  } sps_state_t;
endpackage

//--- src/sps_speed_pid.sv
// closed-loop speed pid for two channels with status led
`timescale 1ns/1ns
// What this block does
// - every 16 ms sample speed, error is desired minus measured
// - proportional term is error times the shared proportional gain
// - differential term is error change since last period times gain
// - error is accumulated and its scaled sum adds an integral term
// - adc mid-scale reads 0, top +127, zero -127
// - one gain set serves both channels
// - missing feedback keeps raising power up to full output
// - one second after power-up the led blinks the mode pattern
// - led solid on while a recoverable fault disables the output
// - faults cleared: output re-enabled, mode blink resumes
// - non-recoverable shutdown: fast blink, output off until reset
// - emergency stop enters the latched fast-blink off state
// - regulator active in both-speed modes or speed/position mode
module sps_speed_pid
  import sps_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int UPDATE_CYCLES = UPDATE_CYC,
  parameter int SLOW_CYCLES = BLINK_SLOW_CYC,
  parameter int FAST_CYCLES = BLINK_FAST_CYC
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic [2:0] MODE,
  input wire logic signed [7:0] DESIRED_1,
  input wire logic signed [7:0] DESIRED_2,
  input wire logic [7:0] ADC_1,
  input wire logic [7:0] ADC_2,
  input wire logic [7:0] GAIN_P,
  input wire logic [7:0] GAIN_I,
  input wire logic [7:0] GAIN_D,
  input wire logic OVER_TEMP,
  input wire logic OVER_VOLT,
  input wire logic UNDER_VOLT,
  input wire logic DEAD_MAN,
  input wire logic ESTOP,
  input wire logic SHUTDOWN,
  output logic signed [7:0] POWER_1,
  output logic signed [7:0] POWER_2,
  output logic OUT_EN,
  output logic LED
);
  if (UPDATE_CYCLES < 2 || SLOW_CYCLES < 2 || FAST_CYCLES < 2 ||
      STARTUP_CYCLES < 1) begin
    $error("sps_speed_pid: counts too small");
  end

  // mid-scale offset removal, 0 pinned to -127
  function automatic logic signed [7:0] adc_to_speed(input logic [7:0] a);
    logic signed [8:0] v;
    v = $signed({1'b0, a}) - $signed({1'b0, ADC_MID});
    if (v < 9'(SPD_MIN))
      return SPD_MIN;
    return v[7:0];
  endfunction

  function automatic logic signed [7:0] sat8(input logic signed [31:0] v);
    if (v > 32'(PWR_MAX))
      return PWR_MAX;
    if (v < 32'(PWR_MIN))
      return PWR_MIN;
    return v[7:0];
  endfunction

  function automatic logic signed [15:0] sat_int(
    input logic signed [16:0] v
  );
    if (v > 17'(INT_LIM))
      return INT_LIM;
    if (v < -17'(INT_LIM))
      return -INT_LIM;
    return v[15:0];
  endfunction

  // both channels share the same gain ports, no per-channel gains
  function automatic logic signed [31:0] pid_sum(
    input logic signed [8:0] err,
    input logic signed [8:0] prev,
    input logic signed [15:0] acc,
    input logic [7:0] gp,
    input logic [7:0] gi,
    input logic [7:0] gd
  );
    logic signed [31:0] p;
    logic signed [31:0] d;
    logic signed [31:0] i;
    p = 32'(err) * $signed({24'h0, gp});
    d = (32'(err) - 32'(prev)) * $signed({24'h0, gd});
    i = 32'(acc) * $signed({24'h0, gi});
    return (p + d + i) >>> GAIN_SHIFT;
  endfunction

  sps_state_t st_q;
  logic [31:0] tick_q;
  logic [31:0] start_q;
  logic [31:0] blink_q;
  logic led_q;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [7:0] adc1_m_q;
  logic [7:0] adc1_q;
  logic [7:0] adc2_m_q;
  logic [7:0] adc2_q;
  logic signed [8:0] prev1_q;
  logic signed [8:0] prev2_q;
  logic signed [15:0] acc1_q;
  logic signed [15:0] acc2_q;
  logic signed [7:0] pwr1_q;
  logic signed [7:0] pwr2_q;
  logic sample;
  logic fault;
  logic estop_s;
  logic shut_s;
  logic active;
  logic pos2;
  logic signed [8:0] err1;
  logic signed [8:0] err2;
  logic signed [15:0] acc1_d;
  logic signed [15:0] acc2_d;

  // fault, stop, shutdown and adc pins pass two flops before use
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {SHUTDOWN, ESTOP, DEAD_MAN, UNDER_VOLT, OVER_VOLT,
                  OVER_TEMP};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      adc1_m_q <= ADC_MID;
      adc1_q <= ADC_MID;
      adc2_m_q <= ADC_MID;
      adc2_q <= ADC_MID;
    end else begin
      adc1_m_q <= ADC_1;
      adc1_q <= adc1_m_q;
      adc2_m_q <= ADC_2;
      adc2_q <= adc2_m_q;
    end
  end

  assign fault = |sync2_q[3:0];
  assign estop_s = sync2_q[4];
  assign shut_s = sync2_q[5];

  assign active = (MODE == 3'(SPS_MODE_SPD_SEP)) ||
                  (MODE == 3'(SPS_MODE_SPD_MIX)) ||
                  (MODE == 3'(SPS_MODE_SPD_POS));
  assign pos2 = (MODE == 3'(SPS_MODE_SPD_POS));

  // 16 ms update strobe
  always_ff @(posedge CLOCK) begin
    if (SRST)
      tick_q <= '0;
    else if (tick_q == 32'(UPDATE_CYCLES - 1))
      tick_q <= '0;
    else
      tick_q <= tick_q + 32'd1;
  end
  assign sample = (tick_q == 32'(UPDATE_CYCLES - 1));

  // error = desired - measured
  assign err1 = 9'(DESIRED_1) - 9'(adc_to_speed(adc1_q));
  assign err2 = 9'(DESIRED_2) - 9'(adc_to_speed(adc2_q));
  // limited so a dead sensor still winds power to full, not past it
  assign acc1_d = sat_int(17'(acc1_q) + 17'(err1));
  assign acc2_d = sat_int(17'(acc2_q) + 17'(err2));

  // integrator and previous-error state
  always_ff @(posedge CLOCK) begin
    if (SRST || !active || st_q != SPS_ST_RUN) begin
      acc1_q <= '0;
      acc2_q <= '0;
      prev1_q <= '0;
      prev2_q <= '0;
    end else if (sample) begin
      acc1_q <= acc1_d;
      prev1_q <= err1;
      if (!pos2) begin
        acc2_q <= acc2_d;
        prev2_q <= err2;
      end
    end
  end

  // power commands, updated once per period
  always_ff @(posedge CLOCK) begin
    if (SRST || !active || st_q != SPS_ST_RUN) begin
      pwr1_q <= '0;
      pwr2_q <= '0;
    end else if (sample) begin
      pwr1_q <= sat8(pid_sum(err1, prev1_q, acc1_d, GAIN_P, GAIN_I,
                             GAIN_D));
      if (!pos2)
        pwr2_q <= sat8(pid_sum(err2, prev2_q, acc2_d, GAIN_P, GAIN_I,
                               GAIN_D));
    end
  end
  assign POWER_1 = pwr1_q;
  assign POWER_2 = pwr2_q;

  // operating state
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st_q <= SPS_ST_START;
      start_q <= '0;
    end else begin
      case (st_q)
        SPS_ST_START: begin
          if (estop_s || shut_s)
            st_q <= SPS_ST_LATCH;
          else if (start_q == 32'(STARTUP_CYCLES - 1))
            st_q <= SPS_ST_RUN;
          else
            start_q <= start_q + 32'd1;
        end
        SPS_ST_RUN: begin
          if (estop_s || shut_s)
            st_q <= SPS_ST_LATCH;
          else if (fault)
            st_q <= SPS_ST_HOLD;
        end
        SPS_ST_HOLD: begin
          if (estop_s || shut_s)
            st_q <= SPS_ST_LATCH;
          else if (!fault)
            st_q <= SPS_ST_RUN;
        end
        SPS_ST_LATCH:
          st_q <= SPS_ST_LATCH;
        default:
          st_q <= SPS_ST_LATCH;
      endcase
    end
  end

  assign OUT_EN = (st_q == SPS_ST_RUN);

  // blink generator: mode pattern as blink rate by mode
  logic [31:0] half;
  always_comb begin
    half = 32'(SLOW_CYCLES) + 32'(MODE) * 32'(FAST_CYCLES);
    if (st_q == SPS_ST_LATCH)
      half = 32'(FAST_CYCLES);
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      blink_q <= '0;
      led_q <= 1'b0;
    end else if (st_q == SPS_ST_START) begin
      blink_q <= '0;
      led_q <= 1'b0;
    end else if (st_q == SPS_ST_HOLD) begin
      blink_q <= '0;
      led_q <= 1'b1;
    end else if (blink_q >= half - 32'd1) begin
      blink_q <= '0;
      led_q <= ~led_q;
    end else begin
      blink_q <= blink_q + 32'd1;
    end
  end
  assign LED = led_q;

  property p_latch_off;
    @(posedge CLOCK) disable iff (SRST)
      st_q == SPS_ST_LATCH |=> (st_q == SPS_ST_LATCH) && !OUT_EN;
  endproperty
  a_latch_off: assert property (p_latch_off)
    else $error("latched shutdown left");

  property p_estop;
    @(posedge CLOCK) disable iff (SRST)
      $rose(estop_s) |=> st_q == SPS_ST_LATCH;
  endproperty
  a_estop: assert property (p_estop)
    else $error("estop did not latch");

  property p_fault_led;
    @(posedge CLOCK) disable iff (SRST)
      st_q == SPS_ST_HOLD ##1 st_q == SPS_ST_HOLD |-> LED && !OUT_EN;
  endproperty
  a_fault_led: assert property (p_fault_led)
    else $error("fault led not solid");

  property p_recover;
    @(posedge CLOCK) disable iff (SRST)
      st_q == SPS_ST_HOLD && !fault && !estop_s && !shut_s |=> OUT_EN;
  endproperty
  a_recover: assert property (p_recover)
    else $error("no recovery");

  property p_pwr_hold;
    @(posedge CLOCK) disable iff (SRST)
      !sample && active && OUT_EN && $past(OUT_EN) |=> $stable(POWER_1);
  endproperty
  a_pwr_hold: assert property (p_pwr_hold)
    else $error("power changed off tick");

  property p_pwr_range;
    @(posedge CLOCK) disable iff (SRST)
      POWER_1 >= PWR_MIN && POWER_2 >= PWR_MIN;
  endproperty
  a_pwr_range: assert property (p_pwr_range)
    else $error("power out of range");

  property p_inactive;
    @(posedge CLOCK) disable iff (SRST)
      !active |=> POWER_1 == 8'sh00 && POWER_2 == 8'sh00;
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("power while loop inactive");

  property p_acc_lim;
    @(posedge CLOCK) disable iff (SRST)
      acc1_q <= INT_LIM && acc1_q >= -INT_LIM;
  endproperty
  a_acc_lim: assert property (p_acc_lim)
    else $error("integrator past limit");

  property p_start_dark;
    @(posedge CLOCK) disable iff (SRST)
      st_q == SPS_ST_START |-> !LED && !OUT_EN;
  endproperty
  a_start_dark: assert property (p_start_dark)
    else $error("activity before startup delay");
endmodule

//--- bench/sps_tach_model.sv
// tachometer stand-in for the speed regulator bench
`timescale 1ns/1ns
module sps_tach_model (
  input wire logic signed [7:0] speed,
  input wire logic absent,
  output logic [7:0] adc
);
  // mid-scale is zero, -127..+127 lands on 0x01..0xff
  // a lost sensor floats to the divider mid-point
  assign adc = absent ? 8'h80 : 8'(speed) + 8'h80;
endmodule

//--- bench/testbench.sv
// self-checking bench for the closed-loop speed regulator
`timescale 1ns/1ns
module testbench;
  import sps_pkg::*;
  localparam int UPD = 16;
  typedef struct {
    logic [2:0] m;
    logic signed [7:0] d1, s1, d2, s2;
    logic [7:0] p;
    logic signed [7:0] e1, e2;
  } sps_row_t;
  // gains i and d held at zero here so only the p term shows
  sps_row_t rows [7] = '{
    '{3'h1, 8'sh0a, 8'sh00, -8'sh0a, 8'sh00, 8'h10, 8'sh0a, -8'sh0a},
    '{3'h1, 8'sh64, -8'sh64, -8'sh14, 8'sh0a, 8'hff, 8'sh7f, -8'sh7f},
    '{3'h2, 8'sh1e, 8'sh00, 8'sh00, 8'sh00, 8'h20, 8'sh3c, 8'sh00},
    '{3'h0, 8'sh1e, 8'sh00, 8'sh1e, 8'sh00, 8'h20, 8'sh00, 8'sh00},
    '{3'h4, 8'sh1e, 8'sh00, 8'sh1e, 8'sh00, 8'h20, 8'sh00, 8'sh00},
    '{3'h1, -8'sh7f, 8'sh7f, 8'sh05, 8'sh05, 8'hff, -8'sh7f, 8'sh00},
    '{3'h3, 8'sh14, 8'sh00, 8'sh32, 8'sh00, 8'h10, 8'sh14, 8'sh00}};
  logic CLOCK, SRST, absent, out_en, led, estop, shut;
  logic f_t, f_ov, f_uv, f_dm;
  logic [2:0] mode;
  logic signed [7:0] des_1, des_2, spd_1, spd_2, pwr_1, pwr_2;
  logic [7:0] adc_1, adc_2, g_p, g_i, g_d;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  sps_speed_pid #(.STARTUP_CYCLES(20), .UPDATE_CYCLES(UPD),
    .SLOW_CYCLES(8), .FAST_CYCLES(2)) DUT (.CLOCK(CLOCK), .SRST(SRST),
    .MODE(mode), .DESIRED_1(des_1), .DESIRED_2(des_2), .ADC_1(adc_1),
    .ADC_2(adc_2), .GAIN_P(g_p), .GAIN_I(g_i), .GAIN_D(g_d),
    .OVER_TEMP(f_t), .OVER_VOLT(f_ov), .UNDER_VOLT(f_uv),
    .DEAD_MAN(f_dm), .ESTOP(estop), .SHUTDOWN(shut), .POWER_1(pwr_1),
    .POWER_2(pwr_2), .OUT_EN(out_en), .LED(led));
  sps_tach_model tach_1 (.speed(spd_1), .absent(absent), .adc(adc_1));
  sps_tach_model tach_2 (.speed(spd_2), .absent(absent), .adc(adc_2));

  initial begin
    CLOCK = 0;
    forever #10 CLOCK = ~CLOCK;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // run needs about 1600 cycles
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (e !== g) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(string n, logic e, logic g);
    cmp_count++;
    if (e !== g) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  // inputs always move 2 ns after the edge
  task automatic wait_cyc(int n);
    repeat (n) @(posedge CLOCK);
    #2;
  endtask

  task automatic step_wait(logic [7:0] old);
    for (int n = 0; n < 40 && pwr_1 === old; n++) wait_cyc(1);
  endtask

  task automatic led_half(int e);
    int n;
    logic l;
    for (int k = 0; k < 2; k++) begin
      l = led;
      n = 0;
      while (led === l && n < 200) begin
        wait_cyc(1);
        n++;
      end
    end
    chk8("led half period", 8'(e), 8'(n));
  endtask

  task automatic do_reset(int n);
    SRST = 1;
    wait_cyc(n);
    SRST = 0;
  endtask

  initial begin
    {absent, estop, shut, f_t, f_ov, f_uv, f_dm} = 7'h00;
    {des_1, des_2, spd_1, spd_2, g_p, g_i, g_d} = 56'h0;
    mode = 3'h1;
    do_reset(16);
    chk8("power reset", 8'h00, pwr_1);
    wait_cyc(15);
    chk1("led start", 1'b0, led);
    chk1("out_en start", 1'b0, out_en);
    wait_cyc(10);
    chk1("out_en run", 1'b1, out_en);
    led_half(10);
    $display("reset and startup done");
    foreach (rows[i]) begin
      mode = rows[i].m;
      {des_1, spd_1, des_2, spd_2} = {rows[i].d1, rows[i].s1,
        rows[i].d2, rows[i].s2};
      g_p = rows[i].p;
      wait_cyc(4 * UPD);
      chk8("power 1", rows[i].e1, pwr_1);
      chk8("power 2", rows[i].e2, pwr_2);
      $display("row %0d done", i);
    end
    {mode, des_1, spd_1, g_p, g_d} = {3'h1, 8'h0, 8'h0, 8'h10, 8'h20};
    wait_cyc(4 * UPD);
    des_1 = 8'sh0a;
    step_wait(8'h00);
    chk8("power step", 8'h1e, pwr_1);
    wait_cyc(UPD);
    chk8("power settled", 8'h0a, pwr_1);
    $display("differential test done");
    // reset clears the integrator left over from earlier tests
    {g_p, g_d, g_i, des_1, des_2, absent} = {24'h10, 16'h0500, 1'b1};
    do_reset(2);
    step_wait(8'h00);
    chk8("integral 1", 8'h05, pwr_1);
    wait_cyc(UPD);
    chk8("integral 2", 8'h0a, pwr_1);
    wait_cyc(30 * UPD);
    chk8("integral full", 8'h7f, pwr_1);
    $display("integral test done");
    for (int k = 0; k < 4; k++) begin
      {f_t, f_ov, f_uv, f_dm} = 4'h8 >> k;
      wait_cyc(5);
      chk1("out_en fault", 1'b0, out_en);
      chk8("power fault", 8'h00, pwr_1);
      repeat (3) begin
        wait_cyc(9);
        chk1("led solid", 1'b1, led);
      end
      {f_t, f_ov, f_uv, f_dm} = 4'h0;
      wait_cyc(5);
      chk1("out_en back", 1'b1, out_en);
      led_half(10);
    end
    mode = 3'h4;
    led_half(16);
    $display("fault test done");
    mode = 3'h1;
    for (int k = 0; k < 2; k++) begin
      wait_cyc(2 * UPD);
      chk8("power before latch", 8'h0a, pwr_1);
      {estop, shut} = k ? 2'b10 : 2'b01;
      wait_cyc(5);
      {estop, shut} = 2'b00;
      wait_cyc(20);
      chk1("out_en latched", 1'b0, out_en);
      chk8("power latched", 8'h00, pwr_1);
      led_half(2);
      do_reset(2);
      wait_cyc(25);
      chk1("out_en cleared", 1'b1, out_en);
    end
    $display("latch test done");
    stop_test();
  end
endmodule
